// File: design/injection_pump_modbus_regs.sv
// Holding-register bank of the injection pump controller.
// Assumes requests come from a Modbus front end on core_clk_i, one word per request,
// and that status inputs are already synchronous to core_clk_i.
`timescale 1ns/100ps
`default_nettype none
module injection_pump_modbus_regs #(
   parameter int unsigned LINK_TIMEOUT_CYCLES = pump_regs_pkg::LINK_TIMEOUT_CYC
) (
   input  wire logic                      core_clk_i,
   input  wire logic                      srst_i,
   input  wire logic                      ce_i,
   input  wire pump_regs_pkg::reg_req_s   req_i,
   input  wire pump_regs_pkg::core_stat_s stat_i,
   output var  pump_regs_pkg::reg_rsp_s   rsp_o,
   output var  pump_regs_pkg::pump_ctl_s  ctl_o
);
   import pump_regs_pkg::*;

   function automatic logic in_window(input logic [31:0] v,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   function automatic logic within_s(input logic [31:0] v,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
      return ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
   endfunction

   // Level words are treated as signed so a negative entry is caught
   function automatic logic [15:0] clamp_level(input logic [15:0] v);
      if (v[15]) return 16'h0000;
      if (v > LEVEL_MAX) return LEVEL_MAX;
      return v;
   endfunction

   function automatic logic [15:0] pad6(input logic [5:0] v);
      return {10'h000, v};
   endfunction

   logic               cmd_run;
   logic [15:0]        grand_total;
   logic [15:0]        flow_rate;
   logic [15:0]        tick_value;
   logic               loss_en;
   logic [15:0]        warn_level;
   logic [15:0]        stop_level;
   logic [15:0]        stage_hi;
   logic               aout_on;
   logic [5:0]         aout_lo;
   logic [5:0]         aout_hi;
   logic [1:0]         tmode;
   logic signed [7:0]  tthr;
   logic [15:0]        rd_word;
   logic               rd_hit;
   logic [2:0]         pump_code;
   logic               wd_lost;
   logic [15:0]        wd_beats;

   wire        wr      = req_i.valid & req_i.write;
   wire [15:0] wd      = req_i.wdata;
   wire [31:0] full32  = {stage_hi, req_i.wdata};
   wire        wd_bool = (wd == 16'h0000) | (wd == 16'h0001);

   wire wr_state   = wr & (req_i.addr == ADR_STATE_LO);
   wire wr_total   = wr & (req_i.addr == ADR_TOTAL);
   wire wr_flow    = wr & (req_i.addr == ADR_FLOW);
   wire wr_inhibit = wr & (req_i.addr == ADR_INHIBIT);
   wire wr_clear   = wr & (req_i.addr == ADR_CLEAR);
   wire wr_tick    = wr & (req_i.addr == ADR_TICK);
   wire wr_loss_en = wr & (req_i.addr == ADR_LOSS_EN);
   wire wr_warn    = wr & (req_i.addr == ADR_WARN);
   wire wr_stop    = wr & (req_i.addr == ADR_STOP);
   wire wr_aosw    = wr & (req_i.addr == ADR_AOSW + ADR_LO_STEP);
   wire wr_aolo    = wr & (req_i.addr == ADR_AOLO + ADR_LO_STEP);
   wire wr_aohi    = wr & (req_i.addr == ADR_AOHI + ADR_LO_STEP);
   wire wr_tmode   = wr & (req_i.addr == ADR_TMODE + ADR_LO_STEP);
   wire wr_tthr    = wr & (req_i.addr == ADR_TTHR + ADR_LO_STEP);

   // High words of writable pairs only stage; the low word commits both
   wire wr_any_hi  = wr & ((req_i.addr == ADR_AOSW) | (req_i.addr == ADR_AOLO) |
                           (req_i.addr == ADR_AOHI) | (req_i.addr == ADR_TMODE) |
                           (req_i.addr == ADR_TTHR));

   wire state_ok   = wr_state & wd_bool;
   wire inhibit_ok = wr_inhibit & wd_bool;
   wire flow_ok    = wr_flow & in_window({16'h0000, wd}, {16'h0000, FLOW_MIN},
                                         {16'h0000, FLOW_MAX});
   wire total_ok   = wr_total & (wd <= TOTAL_WRAP);
   wire clear_ok   = wr_clear & (wd == 16'h0001);
   wire aolo_ok    = wr_aolo & in_window(full32, 32'h0, AOUT_MAX);
   wire aohi_ok    = wr_aohi & in_window(full32, 32'h0, AOUT_MAX);
   wire aosw_ok    = wr_aosw & in_window(full32, 32'h0, 32'h1);
   wire tmode_ok   = wr_tmode & in_window(full32, 32'h0, TMODE_MAX);
   wire tthr_ok    = wr_tthr & within_s(full32, TEMP_MIN, TEMP_MAX);

   wire total_step = stat_i.flow_mode & stat_i.flow_tick;
   wire [15:0] next_total = (grand_total >= TOTAL_WRAP) ? 16'h0000
                                                       : grand_total + 16'h0001;

   assign pump_code = stat_i.lock_alarm  ? PST_LK_ALRM :
                      stat_i.lock_remote ? PST_LK_RMT  :
                      stat_i.lock_power  ? PST_LK_PWR  :
                      stat_i.lock_temp   ? PST_LK_TEMP :
                      cmd_run            ? PST_RUN     : PST_STANDBY;

   wire signed [15:0] temp_now   = $signed(stat_i.temp);
   wire signed [15:0] thr_wide   = 16'(tthr);
   wire               th_armed   = (tmode == TM_BELOW) | (tmode == TM_ABOVE);
   wire               th_demand  = ((tmode == TM_BELOW) & (temp_now < thr_wide)) |
                                   ((tmode == TM_ABOVE) & (temp_now > thr_wide));

   wire [15:0] tthr_hi = {16{tthr[7]}};
   wire [15:0] tthr_lo = {{8{tthr[7]}}, tthr};
   wire [15:0] temp_hi = {16{stat_i.temp[15]}};

   // Mirrors and writable copies read the same held settings
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = 16'h0000;
      case (req_i.addr)
         ADR_STATE_HI:               rd_word = 16'h0000;
         ADR_STATE_LO:               rd_word = {13'h0000, pump_code};
         ADR_TOTAL:                  rd_word = grand_total;
         ADR_FLOW:                   rd_word = flow_rate;
         ADR_INHIBIT:                rd_word = {15'h0000, ~cmd_run};
         ADR_CLEAR:                  rd_word = 16'h0000;
         ADR_TICK:                   rd_word = tick_value;
         ADR_LOSS_EN:                rd_word = {15'h0000, loss_en};
         ADR_WARN:                   rd_word = warn_level;
         ADR_STOP:                   rd_word = stop_level;
         ADR_AOSW_M, ADR_AOSW:       rd_word = 16'h0000;
         ADR_AOLO_M, ADR_AOLO:       rd_word = 16'h0000;
         ADR_AOHI_M, ADR_AOHI:       rd_word = 16'h0000;
         ADR_AOKIND:                 rd_word = 16'h0000;
         ADR_TMODE_M, ADR_TMODE:     rd_word = 16'h0000;
         ADR_TEMP:                   rd_word = temp_hi;
         ADR_TTHR_M, ADR_TTHR:       rd_word = tthr_hi;
         ADR_AOSW_M + ADR_LO_STEP,
         ADR_AOSW + ADR_LO_STEP:     rd_word = {15'h0000, aout_on};
         ADR_AOLO_M + ADR_LO_STEP,
         ADR_AOLO + ADR_LO_STEP:     rd_word = pad6(aout_lo);
         ADR_AOHI_M + ADR_LO_STEP,
         ADR_AOHI + ADR_LO_STEP:     rd_word = pad6(aout_hi);
         ADR_AOKIND + ADR_LO_STEP:   rd_word = {12'h000, stat_i.aout_kind};
         ADR_TEMP + ADR_LO_STEP:     rd_word = stat_i.temp;
         ADR_TMODE_M + ADR_LO_STEP,
         ADR_TMODE + ADR_LO_STEP:    rd_word = {14'h0000, tmode};
         ADR_TTHR_M + ADR_LO_STEP,
         ADR_TTHR + ADR_LO_STEP:     rd_word = tthr_lo;
         default:                    rd_hit  = 1'b0;
      endcase
   end

   link_watchdog #(
      .TIMEOUT_CYCLES (LINK_TIMEOUT_CYCLES)
   ) u_watchdog (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .ce_i       (ce_i),
      .enable_i   (loss_en),
      .tick_i     (wr_tick),
      .clear_i    (clear_ok),
      .lost_o     (wd_lost),
      .beats_o    (wd_beats)
   );

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cmd_run <= 1'b0;
      end else if (ce_i) begin
         if (state_ok) cmd_run <= wd[0];
         else if (inhibit_ok) cmd_run <= ~wd[0];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         grand_total <= 16'h0000;
      end else if (ce_i) begin
         if (total_ok) grand_total <= wd;
         else if (total_step) grand_total <= next_total;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         flow_rate  <= FLOW_RST;
         tick_value <= 16'h0000;
         loss_en    <= 1'b0;
         warn_level <= 16'h0000;
         stop_level <= 16'h0000;
      end else if (ce_i) begin
         if (flow_ok) flow_rate <= wd;
         if (wr_tick) tick_value <= wd;
         if (wr_loss_en && wd_bool) loss_en <= wd[0];
         if (wr_warn) warn_level <= clamp_level(wd);
         if (wr_stop) stop_level <= clamp_level(wd);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         stage_hi <= 16'h0000;
         aout_on  <= 1'b0;
         aout_lo  <= 6'h00;
         aout_hi  <= AOUT_HI_RST;
         tmode    <= TM_OFF;
         tthr     <= 8'sh00;
      end else if (ce_i) begin
         if (wr_any_hi) stage_hi <= wd;
         if (aosw_ok) aout_on <= full32[0];
         if (aolo_ok) aout_lo <= full32[5:0];
         if (aohi_ok) aout_hi <= full32[5:0];
         if (tmode_ok) tmode <= full32[1:0];
         if (tthr_ok) tthr <= $signed(full32[7:0]);
      end
   end

   // Answer one cycle after the request; unmapped words flag err
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rsp_o <= '0;
      end else if (ce_i) begin
         rsp_o.ack   <= req_i.valid;
         rsp_o.err   <= req_i.valid & ~rd_hit;
         rsp_o.rdata <= (req_i.valid && !req_i.write && rd_hit) ? rd_word : 16'h0000;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ctl_o <= '0;
      end else if (ce_i) begin
         ctl_o.pump_code        <= pump_code;
         ctl_o.pump_run         <= (pump_code == PST_RUN);
         ctl_o.flow_rate_active <= stat_i.flow_mode & ~stat_i.analog_in_en;
         ctl_o.flow_rate        <= flow_rate;
         ctl_o.level_warn       <= warn_level;
         ctl_o.level_stop       <= stop_level;
         ctl_o.aout_active      <= aout_on;
         ctl_o.aout_floor       <= aout_on ? aout_lo : 6'h00;
         ctl_o.aout_ceiling     <= aout_on ? aout_hi : 6'h00;
         ctl_o.thermal_active   <= th_armed;
         ctl_o.thermal_demand   <= th_armed & th_demand;
         ctl_o.alarm_clear      <= clear_ok;
         // loss flag for alarm bit 4
         ctl_o.link_loss        <= wd_lost;
         ctl_o.beat_count       <= wd_beats;
      end
   end
endmodule
`default_nettype wire

// File: pkg/pump_regs_pkg.sv
// Register map, codes, limits and carriers of the pump holding-register bank.
// Assumes 16-bit words at Modbus register numbers; a 32-bit value is two words, high first.
package pump_regs_pkg;
   localparam int unsigned CLK_HZ           = 25_000_000;
   localparam int unsigned LINK_TIMEOUT_MS  = 10;
   localparam int unsigned LINK_TIMEOUT_CYC = LINK_TIMEOUT_MS * (CLK_HZ / 1000);

   typedef logic [19:0] reg_addr_t;
   localparam reg_addr_t ADR_STATE_HI = 20'h61f02;
   localparam reg_addr_t ADR_STATE_LO = 20'h61f03;
   localparam reg_addr_t ADR_TOTAL    = 20'h61f04;
   localparam reg_addr_t ADR_FLOW     = 20'h61f05;
   localparam reg_addr_t ADR_INHIBIT  = 20'h61f06;
   localparam reg_addr_t ADR_CLEAR    = 20'h61f07;
   localparam reg_addr_t ADR_TICK     = 20'h61f08;
   localparam reg_addr_t ADR_LOSS_EN  = 20'h61f09;
   localparam reg_addr_t ADR_WARN     = 20'h61f0a;
   localparam reg_addr_t ADR_STOP     = 20'h61f0b;
   localparam reg_addr_t ADR_AOSW_M   = 20'h61f0c;
   localparam reg_addr_t ADR_AOLO_M   = 20'h61f0e;
   localparam reg_addr_t ADR_AOHI_M   = 20'h61f10;
   localparam reg_addr_t ADR_AOKIND   = 20'h61f12;
   localparam reg_addr_t ADR_AOSW     = 20'h61f14;
   localparam reg_addr_t ADR_AOLO     = 20'h61f16;
   localparam reg_addr_t ADR_AOHI     = 20'h61f18;
   localparam reg_addr_t ADR_TEMP     = 20'h61f1a;
   localparam reg_addr_t ADR_TMODE_M  = 20'h61f1c;
   localparam reg_addr_t ADR_TTHR_M   = 20'h61f1e;
   localparam reg_addr_t ADR_TMODE    = 20'h61f20;
   localparam reg_addr_t ADR_TTHR     = 20'h61f22;
   localparam reg_addr_t ADR_LO_STEP  = 20'h00001;

   localparam logic [2:0] PST_STANDBY = 3'h0;
   localparam logic [2:0] PST_RUN     = 3'h1;
   localparam logic [2:0] PST_LK_ALRM = 3'h2;
   localparam logic [2:0] PST_LK_RMT  = 3'h3;
   localparam logic [2:0] PST_LK_PWR  = 3'h4;
   localparam logic [2:0] PST_LK_TEMP = 3'h5;

   localparam logic [1:0] TM_OFF     = 2'h0;
   localparam logic [1:0] TM_DISPLAY = 2'h1;
   localparam logic [1:0] TM_BELOW   = 2'h2;
   localparam logic [1:0] TM_ABOVE   = 2'h3;

   localparam logic [15:0] TOTAL_WRAP  = 16'h7fff;
   localparam logic [15:0] FLOW_MIN    = 16'h000a;
   localparam logic [15:0] FLOW_MAX    = 16'hea60;
   localparam logic [15:0] LEVEL_MAX   = 16'h3840;
   localparam logic [31:0] AOUT_MAX    = 32'h0000003b;
   localparam logic [31:0] TMODE_MAX   = 32'h00000003;
   localparam logic [31:0] TEMP_MIN    = 32'hffffffd8;
   localparam logic [31:0] TEMP_MAX    = 32'h00000076;

   localparam logic [15:0] FLOW_RST    = 16'h000a;
   localparam logic [5:0]  AOUT_HI_RST = 6'h3b;

   typedef struct packed {
      logic        valid;
      logic        write;
      reg_addr_t   addr;
      logic [15:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [15:0] rdata;
   } reg_rsp_s;

   typedef struct packed {
      logic        flow_mode;
      logic        analog_in_en;
      logic        lock_alarm;
      logic        lock_remote;
      logic        lock_power;
      logic        lock_temp;
      logic        flow_tick;
      logic [15:0] temp;
      logic [3:0]  aout_kind;
   } core_stat_s;

   typedef struct packed {
      logic [2:0]  pump_code;
      logic        pump_run;
      logic        flow_rate_active;
      logic [15:0] flow_rate;
      logic [15:0] level_warn;
      logic [15:0] level_stop;
      logic        aout_active;
      logic [5:0]  aout_floor;
      logic [5:0]  aout_ceiling;
      logic        thermal_active;
      logic        thermal_demand;
      logic        alarm_clear;
      logic        link_loss;
      logic [15:0] beat_count;
   } pump_ctl_s;
endpackage

// File: design/link_watchdog.sv
// Heartbeat counter and communications-loss watchdog.
// Assumes tick and clear are single-cycle pulses on core_clk_i.
`timescale 1ns/100ps
`default_nettype none
module link_watchdog #(
   parameter int unsigned TIMEOUT_CYCLES = 250000
) (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic        ce_i,
   input  wire logic        enable_i,
   input  wire logic        tick_i,
   input  wire logic        clear_i,
   output var  logic        lost_o,
   output var  logic [15:0] beats_o
);
   localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);

   typedef enum logic [2:0] {
      WD_OFF   = 3'b001,
      WD_WATCH = 3'b010,
      WD_LOST  = 3'b100
   } wd_state_e;

   wd_state_e      state;
   wd_state_e      next_state;
   logic [CW-1:0]  idle_cnt;
   logic [CW-1:0]  next_idle_cnt;

   wire expired = (idle_cnt == LAST) & ~tick_i;

   always_comb begin
      next_state    = state;
      next_idle_cnt = '0;
      case (state)
         WD_OFF: begin
            if (enable_i) next_state = WD_WATCH;
         end
         WD_WATCH: begin
            next_idle_cnt = tick_i ? '0 : idle_cnt + CW'(1);
            // Timeout outranks a clear arriving together
            if (!enable_i) next_state = WD_OFF;
            else if (expired) next_state = WD_LOST;
         end
         WD_LOST: begin
            if (!enable_i) next_state = WD_OFF;
            else if (clear_i) next_state = WD_WATCH;
         end
         default: next_state = WD_OFF;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state    <= WD_OFF;
         idle_cnt <= '0;
         beats_o  <= '0;
      end else if (ce_i) begin
         state    <= next_state;
         idle_cnt <= next_idle_cnt;
         if (tick_i && enable_i) beats_o <= beats_o + 16'h0001;
      end
   end

   assign lost_o = (state == WD_LOST);
endmodule
`default_nettype wire

// File: tb/pump_regs_asserts.sv
// Port-level assertions for the pump holding-register bank.
// Assumes it is bound onto injection_pump_modbus_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pump_regs_asserts
   import pump_regs_pkg::*;
#(
   parameter int unsigned LINK_TIMEOUT_CYCLES = 16
) (
   input wire logic                      core_clk_i,
   input wire logic                      srst_i,
   input wire logic                      ce_i,
   input wire pump_regs_pkg::reg_req_s   req_i,
   input wire pump_regs_pkg::core_stat_s stat_i,
   input wire pump_regs_pkg::reg_rsp_s   rsp_o,
   input wire pump_regs_pkg::pump_ctl_s  ctl_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   function automatic logic [15:0] clamp_level(input logic [15:0] w);
      if (w[15]) return 16'h0000;
      return (w > LEVEL_MAX) ? LEVEL_MAX : w;
   endfunction

   // Write taken, then two enabled edges until ctl_o shows it
   sequence s_wr_settled(a, ok);
      ce_i && req_i.valid && req_i.write && req_i.addr == a && ok ##1 ce_i [*2];
   endsequence
   // Write taken; its one-flop effects show at the next edge
   sequence s_wr_taken(a);
      ce_i && req_i.valid && req_i.write && req_i.addr == a ##1 ce_i;
   endsequence
   sequence s_rd(a);
      ce_i && req_i.valid && !req_i.write && req_i.addr == a ##1 ce_i;
   endsequence

   property p_ack_latency;
      ce_i && req_i.valid ##1 ce_i |-> rsp_o.ack;
   endproperty
   property p_idle_quiet;
      !rsp_o.ack |-> rsp_o.rdata == 16'h0000 && !rsp_o.err;
   endproperty
   property p_alarm_code;
      ce_i && stat_i.lock_alarm |=> ctl_o.pump_code == PST_LK_ALRM;
   endproperty
   property p_temp_code;
      ce_i && stat_i.lock_temp && !stat_i.lock_alarm && !stat_i.lock_remote
         && !stat_i.lock_power |=> ctl_o.pump_code == PST_LK_TEMP;
   endproperty
   property p_flow_range;
      !$past(srst_i) |-> ctl_o.flow_rate >= FLOW_MIN && ctl_o.flow_rate <= FLOW_MAX;
   endproperty
   property p_flow_store;
      s_wr_settled(ADR_FLOW, req_i.wdata >= FLOW_MIN && req_i.wdata <= FLOW_MAX)
         |-> ctl_o.flow_rate == $past(req_i.wdata, 2);
   endproperty
   property p_level_clamp;
      s_wr_settled(ADR_WARN, 1'b1) |-> ctl_o.level_warn == clamp_level($past(req_i.wdata, 2));
   endproperty
   property p_aout_off;
      !ctl_o.aout_active |-> ctl_o.aout_floor == 6'h00 && ctl_o.aout_ceiling == 6'h00;
   endproperty
   property p_thermal_gate;
      ctl_o.thermal_demand |-> ctl_o.thermal_active;
   endproperty
   property p_clear_pulse;
      s_wr_taken(ADR_CLEAR) |-> ctl_o.alarm_clear == ($past(req_i.wdata) == 16'h0001);
   endproperty
   property p_upper_zero;
      s_rd(ADR_STATE_HI) |-> rsp_o.ack && rsp_o.rdata == 16'h0000;
   endproperty

   a_ack_latency: assert property (p_ack_latency)
      else $error("request not acknowledged one cycle later");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("read data or error without acknowledge");
   a_alarm_code: assert property (p_alarm_code)
      else $error("alarm lockout code missing");
   a_temp_code: assert property (p_temp_code)
      else $error("temperature lockout code missing");
   a_flow_range: assert property (p_flow_range)
      else $error("flow rate outside accepted range");
   a_flow_store: assert property (p_flow_store)
      else $error("accepted flow rate not applied");
   a_level_clamp: assert property (p_level_clamp)
      else $error("level trigger not clamped");
   a_aout_off: assert property (p_aout_off)
      else $error("analog limits applied while output off");
   a_thermal_gate: assert property (p_thermal_gate)
      else $error("thermal demand without active mode");
   a_clear_pulse: assert property (p_clear_pulse)
      else $error("alarm clear pulse wrong");
   a_upper_zero: assert property (p_upper_zero)
      else $error("unused upper word not zero");
endmodule

bind injection_pump_modbus_regs pump_regs_asserts #(
   .LINK_TIMEOUT_CYCLES(LINK_TIMEOUT_CYCLES)
) u_asserts (
   .core_clk_i (core_clk_i),
   .srst_i     (srst_i),
   .ce_i       (ce_i),
   .req_i      (req_i),
   .stat_i     (stat_i),
   .rsp_o      (rsp_o),
   .ctl_o      (ctl_o)
);
`default_nettype wire

// File: tb/modbus_master_model.sv
// Behavioural Modbus master issuing one register word per request.
// Assumes the bank answers with ack one enabled cycle after taking a request.
`timescale 1ns/100ps
`default_nettype none
module modbus_master_model
   import pump_regs_pkg::*;
(
   input  wire logic                    core_clk_i,
   input  wire pump_regs_pkg::reg_rsp_s rsp_i,
   output var  pump_regs_pkg::reg_req_s req_o
);
   initial req_o = '0;

   // Request held one cycle only: valid is a level, so holding it repeats the request
   task automatic xfer(input logic wr, input reg_addr_t a, input logic [15:0] d,
                       output logic [15:0] q, output logic [1:0] st);
      @(negedge core_clk_i);
      req_o = '{valid: 1'b1, write: wr, addr: a, wdata: d};
      @(negedge core_clk_i);
      st = {rsp_i.ack, rsp_i.err};
      q = rsp_i.rdata;
      // Released lines show the inverse, never a stale copy
      req_o = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
   endtask
endmodule
`default_nettype wire

// File: tb/injection_pump_modbus_regs_tb.sv
// Self-checking testbench for the pump holding-register bank.
// Assumes the master model in tb/ and a shortened link timeout.
`timescale 1ns/100ps
`default_nettype none
module injection_pump_modbus_regs_tb;
   import pump_regs_pkg::*;
   localparam int unsigned TMO = 16;
   logic       core_clk = 1'b0;
   logic       srst     = 1'b1;
   logic       ce       = 1'b1;
   core_stat_s stat     = '0;
   reg_req_s   req;
   reg_rsp_s   rsp;
   pump_ctl_s  ctl;
   int         num_errors  = 0;
   int         checks_done = 0;

   always #20 core_clk = ~core_clk;

   modbus_master_model master (.core_clk_i(core_clk), .rsp_i(rsp), .req_o(req));
   injection_pump_modbus_regs #(.LINK_TIMEOUT_CYCLES(TMO)) dut (
      .core_clk_i(core_clk), .srst_i(srst), .ce_i(ce), .req_i(req), .stat_i(stat),
      .rsp_o(rsp), .ctl_o(ctl));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input reg_addr_t a, input logic [15:0] d);
      logic [15:0] q;
      logic [1:0]  st;
      master.xfer(1'b1, a, d, q, st);
      chk({14'h0, st}, 16'h0002);
   endtask
   task automatic rd(input reg_addr_t a, input logic [15:0] exp);
      logic [15:0] q;
      logic [1:0]  st;
      master.xfer(1'b0, a, 16'h0000, q, st);
      chk({14'h0, st}, 16'h0002);
      chk(q, exp);
   endtask
   task automatic wr32(input reg_addr_t a, input logic [31:0] v);
      wr(a, v[31:16]);
      wr(a + ADR_LO_STEP, v[15:0]);
   endtask
   task automatic pulse_tick();
      @(negedge core_clk);
      stat.flow_tick = 1'b1;
      @(negedge core_clk);
      stat.flow_tick = 1'b0;
   endtask

   task automatic t_defaults();
      logic [15:0] q;
      logic [1:0]  st;
      rd(ADR_STATE_HI, 16'h0000);
      rd(ADR_STATE_LO, {13'h0, PST_STANDBY});
      rd(ADR_FLOW, FLOW_RST);
      rd(ADR_AOHI + ADR_LO_STEP, {10'h0, AOUT_HI_RST});
      rd(ADR_CLEAR, 16'h0000);
      master.xfer(1'b0, 20'h61f24, 16'h0000, q, st);
      chk({14'h0, st}, 16'h0003);
   endtask
   task automatic t_pump();
      wr(ADR_INHIBIT, 16'h0000);
      rd(ADR_STATE_LO, {13'h0, PST_RUN});
      chk({15'h0, ctl.pump_run}, 16'h0001);
      wr(ADR_INHIBIT, 16'h0001);
      rd(ADR_STATE_LO, {13'h0, PST_STANDBY});
      wr(ADR_STATE_LO, 16'h0001);
      rd(ADR_INHIBIT, 16'h0000);
      wr(ADR_STATE_LO, 16'h0005);
      rd(ADR_STATE_LO, {13'h0, PST_RUN});
      stat.lock_temp = 1'b1;
      rd(ADR_STATE_LO, {13'h0, PST_LK_TEMP});
      stat.lock_power = 1'b1;
      rd(ADR_STATE_LO, {13'h0, PST_LK_PWR});
      stat.lock_remote = 1'b1;
      rd(ADR_STATE_LO, {13'h0, PST_LK_RMT});
      stat.lock_alarm = 1'b1;
      rd(ADR_STATE_LO, {13'h0, PST_LK_ALRM});
      chk({15'h0, ctl.pump_run}, 16'h0000);
      stat = '0;
      wr(ADR_INHIBIT, 16'h0001);
   endtask
   task automatic t_total_flow();
      stat.flow_mode = 1'b1;
      wr(ADR_TOTAL, TOTAL_WRAP - 16'h0001);
      pulse_tick();
      rd(ADR_TOTAL, TOTAL_WRAP);
      pulse_tick();
      rd(ADR_TOTAL, 16'h0000);
      stat.flow_mode = 1'b0;
      pulse_tick();
      rd(ADR_TOTAL, 16'h0000);
      stat.flow_mode = 1'b1;
      // A tick while frozen must not count
      ce = 1'b0;
      pulse_tick();
      ce = 1'b1;
      rd(ADR_TOTAL, 16'h0000);
      chk({15'h0, ctl.flow_rate_active}, 16'h0001);
      stat.analog_in_en = 1'b1;
      repeat (2) @(negedge core_clk);
      chk({15'h0, ctl.flow_rate_active}, 16'h0000);
      stat.flow_mode = 1'b0;
      stat.analog_in_en = 1'b0;
      wr(ADR_FLOW, FLOW_MIN - 16'h0001);
      rd(ADR_FLOW, FLOW_RST);
      wr(ADR_FLOW, FLOW_MAX);
      wr(ADR_FLOW, FLOW_MAX + 16'h0001);
      rd(ADR_FLOW, FLOW_MAX);
   endtask
   task automatic t_level_aout();
      wr(ADR_WARN, 16'hffff);
      rd(ADR_WARN, 16'h0000);
      wr(ADR_STOP, LEVEL_MAX + 16'h0001);
      rd(ADR_STOP, LEVEL_MAX);
      chk(ctl.level_stop, LEVEL_MAX);
      wr32(ADR_AOLO, AOUT_MAX + 32'h1);
      rd(ADR_AOLO + ADR_LO_STEP, 16'h0000);
      wr32(ADR_AOLO, AOUT_MAX);
      rd(ADR_AOLO + ADR_LO_STEP, AOUT_MAX[15:0]);
      wr32(ADR_AOSW, 32'h00000001);
      repeat (2) @(negedge core_clk);
      chk({10'h0, ctl.aout_floor}, AOUT_MAX[15:0]);
      chk({10'h0, ctl.aout_ceiling}, {10'h0, AOUT_HI_RST});
   endtask
   task automatic t_thermal();
      for (int m = 0; m < 5; m++) begin
         wr32(ADR_TMODE, 32'(m));
         rd(ADR_TMODE + ADR_LO_STEP, (m < 4) ? 16'(m) : 16'h0003);
      end
      wr32(ADR_TTHR, TEMP_MIN - 32'h1);
      rd(ADR_TTHR + ADR_LO_STEP, 16'h0000);
      wr32(ADR_TTHR, TEMP_MIN);
      rd(ADR_TTHR + ADR_LO_STEP, TEMP_MIN[15:0]);
      wr32(ADR_TTHR, TEMP_MAX + 32'h1);
      rd(ADR_TTHR + ADR_LO_STEP, TEMP_MIN[15:0]);
      wr32(ADR_TTHR, TEMP_MAX);
      stat.temp = 16'h0032;
      for (int m = 1; m < 4; m++) begin
         wr32(ADR_TMODE, 32'(m));
         repeat (2) @(negedge core_clk);
         chk({15'h0, ctl.thermal_demand}, (m == 2) ? 16'h0001 : 16'h0000);
      end
      stat.temp = 16'h0077;
      repeat (2) @(negedge core_clk);
      chk({15'h0, ctl.thermal_demand}, 16'h0001);
   endtask
   task automatic t_beat();
      wr(ADR_TICK, 16'h1234);
      repeat (2) @(negedge core_clk);
      chk(ctl.beat_count, 16'h0000);
      wr(ADR_LOSS_EN, 16'h0001);
      wr(ADR_TICK, 16'hffff);
      wr(ADR_TICK, 16'h0000);
      repeat (2) @(negedge core_clk);
      chk(ctl.beat_count, 16'h0002);
      chk({15'h0, ctl.link_loss}, 16'h0000);
      repeat (TMO + 6) @(negedge core_clk);
      chk({15'h0, ctl.link_loss}, 16'h0001);
      wr(ADR_CLEAR, 16'h0000);
      @(negedge core_clk);
      chk({15'h0, ctl.link_loss}, 16'h0001);
      wr(ADR_CLEAR, 16'h0001);
      @(negedge core_clk);
      chk({15'h0, ctl.link_loss}, 16'h0000);
      wr(ADR_LOSS_EN, 16'h0000);
   endtask

   task automatic finish_test();
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(negedge core_clk);
      srst = 1'b0;
      t_defaults();
      t_pump();
      t_total_flow();
      t_level_aout();
      t_thermal();
      t_beat();
      finish_test();
   end

   // Whole sequence needs some 210 cycles; more than twenty times that means a hang
   initial begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
